// [abu_breakpoint.sv]
`timescale 1ns/1ns
`include "abu_defines.svh"

// Functional notes
// - break on full 16-bit address compare only while match enable is set
// - match enable at control bit 7, read/write, cleared by zero write and reset
// - hardware sets break active flag on every enabled address match
// - software writing one to break active flag forces a break
// - break active flag clears on zero write and reset; routine clears it
// - compare value held as separate high and low byte registers
// - both address byte registers reset to zero
// - during break, timer counter halts and input captures are blocked
// - during break, watchdog held off while test high voltage sensed on reset pin
// - clear flag enable read/write; zero blocks status flag clears during break
// - wait exit flag shows wait mode left by a break interrupt
// - in wait and stop no address match break is produced; enable kept
// - break raises request to system integration unit; vector by mode
// - opcode match breaks before execution; operand match after instruction completes
// - forced break taken right before the next instruction begins
module abu_breakpoint (
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic [15:0] CPU_ADDR,
  input  wire logic        CPU_PROG_FETCH,
  input  wire logic        CPU_OPCODE_FETCH,
  input  wire logic        CPU_INSTR_START,
  input  wire logic        CPU_WAIT_MODE,
  input  wire logic        CPU_STOP_MODE,
  input  wire logic        MONITOR_MODE,
  input  wire logic        TEST_HIGH_VOLTAGE,
  input  wire logic        BREAK_STATE,
  input  wire logic        STATUS_CLEAR_REQ,
  output logic             BREAKPOINT_REQUEST,
  output logic      [15:0] BREAK_VECTOR,
  output logic             TIMER_HALT,
  output logic             CAPTURE_BLOCK,
  output logic             WATCHDOG_DISABLE,
  output logic             STATUS_CLEAR_ALLOW,
  output logic             IRQ
);

  logic       match_enable_reg;
  logic       active_reg;
  logic [7:0] addr_high_reg;
  logic [7:0] addr_low_reg;
  logic       clear_enable_reg;
  logic       wait_exit_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_status_next;
  logic [1:0] irq_mask_next;
  logic       in_wait_reg;
  abu_pkg::abu_state_type state_reg;
  abu_pkg::abu_state_type state_next;

  logic wr_ctrl;
  logic forced_break;
  logic addr_hit;
  logic match_opcode;
  logic match_operand;
  logic [1:0] irq_events;

  assign wr_ctrl       = REG_WR && (REG_ADDR == `ABU_OFS_CTRL_STATUS);
  assign forced_break  = wr_ctrl && REG_WDATA[`ABU_BIT_ACTIVE];
  // address bus is frozen in low power modes, so no match there
  assign addr_hit      = match_enable_reg && CPU_PROG_FETCH && !CPU_WAIT_MODE && !CPU_STOP_MODE
                         && (CPU_ADDR == {addr_high_reg, addr_low_reg});
  assign match_opcode  = addr_hit && CPU_OPCODE_FETCH;
  assign match_operand = addr_hit && !CPU_OPCODE_FETCH;
  assign irq_events    = {forced_break, addr_hit};

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      match_enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      match_enable_reg <= REG_WDATA[`ABU_BIT_MATCH_ENABLE];
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      active_reg <= 1'b0;
    end else if (addr_hit || forced_break) begin
      active_reg <= 1'b1;
    end else if (wr_ctrl) begin
      active_reg <= REG_WDATA[`ABU_BIT_ACTIVE];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      addr_high_reg <= `ABU_RST_ADDR;
      addr_low_reg  <= `ABU_RST_ADDR;
    end else if (REG_WR) begin
      if (REG_ADDR == `ABU_OFS_ADDR_HIGH) begin
        addr_high_reg <= REG_WDATA;
      end
      if (REG_ADDR == `ABU_OFS_ADDR_LOW) begin
        addr_low_reg <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      clear_enable_reg <= 1'b0;
    end else if (REG_WR && (REG_ADDR == `ABU_OFS_FLAG_CONTROL)) begin
      clear_enable_reg <= REG_WDATA[`ABU_BIT_CLEAR_ENABLE];
    end
  end

  // wait exit flag: set when a break request ends wait mode
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      in_wait_reg   <= 1'b0;
      wait_exit_reg <= 1'b0;
    end else begin
      in_wait_reg <= CPU_WAIT_MODE;
      if (in_wait_reg && !CPU_WAIT_MODE && BREAKPOINT_REQUEST) begin
        wait_exit_reg <= 1'b1;
      end else if (in_wait_reg && !CPU_WAIT_MODE) begin
        wait_exit_reg <= 1'b0;
      end
    end
  end

  // sequencing of the request toward the system integration unit
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      abu_pkg::ABU_IDLE_TYPE_IDLE: begin
        if (match_opcode || forced_break) begin
          state_next = abu_pkg::ABU_IDLE_TYPE_REQUEST;
        end else if (match_operand) begin
          state_next = abu_pkg::ABU_IDLE_TYPE_OPERAND;
        end
      end
      abu_pkg::ABU_IDLE_TYPE_OPERAND: begin
        if (CPU_INSTR_START) begin
          state_next = abu_pkg::ABU_IDLE_TYPE_REQUEST;
        end
      end
      abu_pkg::ABU_IDLE_TYPE_REQUEST: begin
        if (CPU_INSTR_START || BREAK_STATE) begin
          state_next = abu_pkg::ABU_IDLE_TYPE_IDLE;
        end
      end
      default: begin
        state_next = abu_pkg::ABU_IDLE_TYPE_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= abu_pkg::ABU_IDLE_TYPE_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      BREAKPOINT_REQUEST <= 1'b0;
      BREAK_VECTOR       <= `ABU_VECTOR_USER;
    end else begin
      BREAKPOINT_REQUEST <= (state_next == abu_pkg::ABU_IDLE_TYPE_REQUEST);
      BREAK_VECTOR       <= MONITOR_MODE ? `ABU_VECTOR_MONITOR : `ABU_VECTOR_USER;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      TIMER_HALT         <= 1'b0;
      CAPTURE_BLOCK      <= 1'b0;
      WATCHDOG_DISABLE   <= 1'b0;
      STATUS_CLEAR_ALLOW <= 1'b0;
    end else begin
      TIMER_HALT         <= BREAK_STATE;
      CAPTURE_BLOCK      <= BREAK_STATE;
      WATCHDOG_DISABLE   <= BREAK_STATE && TEST_HIGH_VOLTAGE;
      // outside break, clears always pass; inside, only when enabled
      STATUS_CLEAR_ALLOW <= STATUS_CLEAR_REQ && (!BREAK_STATE || clear_enable_reg);
    end
  end

  // a new event in the clearing cycle still sets its bit
  always_comb begin
    irq_status_next = irq_status_reg | irq_events;
    irq_mask_next   = irq_mask_reg;
    if (REG_WR && (REG_ADDR == `ABU_OFS_IRQ_STATUS)) begin
      irq_status_next = (irq_status_reg & ~REG_WDATA[1:0]) | irq_events;
    end
    if (REG_WR && (REG_ADDR == `ABU_OFS_IRQ_MASK)) begin
      irq_mask_next = REG_WDATA[1:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      irq_status_reg <= 2'b00;
      irq_mask_reg   <= 2'b00;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg   <= irq_mask_next;
    end
  end

  // built from next values so the line drops in the same cycle as the status bit
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status_next & irq_mask_next);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `ABU_OFS_CTRL_STATUS:  REG_RDATA <= {match_enable_reg, active_reg, 6'h00};
        `ABU_OFS_ADDR_HIGH:    REG_RDATA <= addr_high_reg;
        `ABU_OFS_ADDR_LOW:     REG_RDATA <= addr_low_reg;
        `ABU_OFS_WAIT_STATUS:  REG_RDATA <= {6'h00, wait_exit_reg, 1'b0};
        `ABU_OFS_FLAG_CONTROL: REG_RDATA <= {clear_enable_reg, 7'h00};
        `ABU_OFS_IRQ_STATUS:   REG_RDATA <= {6'h00, irq_status_reg};
        `ABU_OFS_IRQ_MASK:     REG_RDATA <= {6'h00, irq_mask_reg};
        default:               REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  sequence seq_hit;
    match_enable_reg && CPU_PROG_FETCH && !CPU_WAIT_MODE && !CPU_STOP_MODE
      && CPU_ADDR == {addr_high_reg, addr_low_reg};
  endsequence

  sequence seq_opcode_hit;
    seq_hit and CPU_OPCODE_FETCH;
  endsequence

  sequence seq_operand_done;
    state_reg == abu_pkg::ABU_IDLE_TYPE_OPERAND && CPU_INSTR_START;
  endsequence

  AST_MATCH_SETS_ACTIVE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    seq_hit |=> active_reg)
    else $error("enabled match did not set active flag");

  AST_NO_MATCH_WHEN_DISABLED: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (!match_enable_reg && !forced_break && state_reg == abu_pkg::ABU_IDLE_TYPE_IDLE) |=> !BREAKPOINT_REQUEST)
    else $error("request raised with matching disabled");

  AST_OPCODE_REQUEST: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (seq_opcode_hit and state_reg == abu_pkg::ABU_IDLE_TYPE_IDLE) |=> BREAKPOINT_REQUEST)
    else $error("opcode match did not request break next cycle");

  AST_FORCED_REQUEST: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (forced_break && state_reg == abu_pkg::ABU_IDLE_TYPE_IDLE) |=> (BREAKPOINT_REQUEST && active_reg))
    else $error("forced break not requested");

  AST_ENABLE_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    wr_ctrl |=> match_enable_reg == $past(REG_WDATA[7]))
    else $error("match enable not written");

  AST_ACTIVE_CLEAR: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (wr_ctrl && !REG_WDATA[6] && !addr_hit) |=> !active_reg)
    else $error("active flag not cleared by zero write");

  AST_LOW_POWER_NO_HIT: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (CPU_WAIT_MODE || CPU_STOP_MODE) |-> !addr_hit)
    else $error("match during low power mode");

  AST_TIMER_HALT: assert property (@(posedge CLOCK) disable iff (!RST_B)
    BREAK_STATE |=> (TIMER_HALT && CAPTURE_BLOCK))
    else $error("timer not halted in break");

  AST_WATCHDOG: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (BREAK_STATE && TEST_HIGH_VOLTAGE) |=> WATCHDOG_DISABLE)
    else $error("watchdog not disabled");

  AST_CLEAR_BLOCKED: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (BREAK_STATE && !clear_enable_reg) |=> !STATUS_CLEAR_ALLOW)
    else $error("status clear allowed while blocked");

  AST_DATA_ONLY_NO_HIT: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !CPU_PROG_FETCH |-> !addr_hit)
    else $error("non program access matched");

  AST_OPERAND_DEFERS: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (match_operand && !forced_break && state_reg == abu_pkg::ABU_IDLE_TYPE_IDLE) |=> !BREAKPOINT_REQUEST)
    else $error("operand match requested before instruction end");

  AST_OPERAND_RELEASE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    seq_operand_done |=> BREAKPOINT_REQUEST)
    else $error("pending operand break not requested");

  AST_REQUEST_HOLDS: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (BREAKPOINT_REQUEST && !CPU_INSTR_START && !BREAK_STATE) |=> BREAKPOINT_REQUEST)
    else $error("request dropped before it was taken");

  AST_REQUEST_ENDS: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (BREAKPOINT_REQUEST && BREAK_STATE) |=> !BREAKPOINT_REQUEST)
    else $error("request kept after break state entered");

  AST_VECTOR_USER: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !MONITOR_MODE |=> BREAK_VECTOR == `ABU_VECTOR_USER)
    else $error("wrong user vector");

  AST_VECTOR_MONITOR: assert property (@(posedge CLOCK) disable iff (!RST_B)
    MONITOR_MODE |=> BREAK_VECTOR == `ABU_VECTOR_MONITOR)
    else $error("wrong monitor vector");

  AST_WATCHDOG_ON: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !TEST_HIGH_VOLTAGE |=> !WATCHDOG_DISABLE)
    else $error("watchdog disabled without test voltage");

  AST_TIMER_RUNS: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !BREAK_STATE |=> (!TIMER_HALT && !CAPTURE_BLOCK))
    else $error("timer held outside break");

  AST_CLEAR_ENABLED: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (BREAK_STATE && clear_enable_reg && STATUS_CLEAR_REQ) |=> STATUS_CLEAR_ALLOW)
    else $error("enabled clear refused in break");

  AST_CLEAR_OUTSIDE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (!BREAK_STATE && STATUS_CLEAR_REQ) |=> STATUS_CLEAR_ALLOW)
    else $error("clear refused outside break");

  AST_FLAG_CONTROL_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (REG_WR && REG_ADDR == `ABU_OFS_FLAG_CONTROL) |=> clear_enable_reg == $past(REG_WDATA[7]))
    else $error("clear enable not written");

  AST_ADDR_HIGH_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (REG_WR && REG_ADDR == `ABU_OFS_ADDR_HIGH) |=> addr_high_reg == $past(REG_WDATA))
    else $error("address high byte not written");

  AST_ADDR_LOW_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (REG_WR && REG_ADDR == `ABU_OFS_ADDR_LOW) |=> addr_low_reg == $past(REG_WDATA))
    else $error("address low byte not written");

  AST_WAIT_EXIT_SET: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (in_wait_reg && !CPU_WAIT_MODE && BREAKPOINT_REQUEST) |=> wait_exit_reg)
    else $error("wait exit flag not set");

  AST_ENABLE_KEPT_LOW_POWER: assert property (@(posedge CLOCK) disable iff (!RST_B)
    ((CPU_WAIT_MODE || CPU_STOP_MODE) && !wr_ctrl) |=> $stable(match_enable_reg))
    else $error("match enable changed in low power mode");

endmodule // abu_breakpoint

// [abu_breakpoint_tb.sv]
`timescale 1ns/1ns
`include "abu_defines.svh"
module abu_breakpoint_tb;
  logic        CLOCK, RST_B, REG_WR, REG_RD, STATUS_CLEAR_REQ;
  logic [3:0]  REG_ADDR;
  logic [7:0]  REG_WDATA, REG_RDATA;
  logic [15:0] CPU_ADDR, BREAK_VECTOR;
  logic        CPU_PROG_FETCH, CPU_OPCODE_FETCH, CPU_INSTR_START, BREAK_STATE;
  logic        CPU_WAIT_MODE, CPU_STOP_MODE, MONITOR_MODE, TEST_HIGH_VOLTAGE;
  logic        BREAKPOINT_REQUEST, TIMER_HALT, CAPTURE_BLOCK, WATCHDOG_DISABLE;
  logic        STATUS_CLEAR_ALLOW, IRQ;
  int          fail_count, checked;
  logic [15:0] seed, a;
  logic [7:0]  v;
  logic        fce, thv, mon, req;
  logic [1:0]  msk;
  logic [3:0]  ra [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7};
  always #20 CLOCK = ~CLOCK;
  abu_breakpoint i_abu_breakpoint (.CLOCK(CLOCK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CPU_ADDR(CPU_ADDR), .CPU_PROG_FETCH(CPU_PROG_FETCH), .CPU_OPCODE_FETCH(CPU_OPCODE_FETCH),
    .CPU_INSTR_START(CPU_INSTR_START), .CPU_WAIT_MODE(CPU_WAIT_MODE), .CPU_STOP_MODE(CPU_STOP_MODE),
    .MONITOR_MODE(MONITOR_MODE), .TEST_HIGH_VOLTAGE(TEST_HIGH_VOLTAGE), .BREAK_STATE(BREAK_STATE),
    .STATUS_CLEAR_REQ(STATUS_CLEAR_REQ), .BREAKPOINT_REQUEST(BREAKPOINT_REQUEST),
    .BREAK_VECTOR(BREAK_VECTOR), .TIMER_HALT(TIMER_HALT), .CAPTURE_BLOCK(CAPTURE_BLOCK),
    .WATCHDOG_DISABLE(WATCHDOG_DISABLE), .STATUS_CLEAR_ALLOW(STATUS_CLEAR_ALLOW), .IRQ(IRQ));
  abu_cpu_model i_abu_cpu_model (.CLOCK(CLOCK), .RST_B(RST_B),
    .HOLD_BUS(CPU_WAIT_MODE | CPU_STOP_MODE), .BREAKPOINT_REQUEST(BREAKPOINT_REQUEST),
    .CPU_ADDR(CPU_ADDR), .CPU_PROG_FETCH(CPU_PROG_FETCH), .CPU_OPCODE_FETCH(CPU_OPCODE_FETCH),
    .CPU_INSTR_START(CPU_INSTR_START), .BREAK_STATE(BREAK_STATE));
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] x;
    x = s ^ (s << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction
  // clears pass outside break, inside only with the enable bit
  function automatic logic exp_clear(input logic brk, input logic en, input logic rq);
    return rq && (!brk || en);
  endfunction
  task automatic finish_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge CLOCK);
    REG_WR <= 1'b1;
    REG_ADDR <= ad;
    REG_WDATA <= d;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge CLOCK);
    REG_RD <= 1'b1;
    REG_ADDR <= ad;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  // cycles from a visible fetch of ad to the request
  task automatic wait_req(input logic [15:0] ad, input int lat);
    int t;
    t = -1;
    // a forced request may stand one cycle only, so look after the write edge settles
    #1;
    for (int i = 0; i < 600 && BREAKPOINT_REQUEST !== 1'b1; i++) begin
      @(posedge CLOCK);
      #1 if (t >= 0) t++;
      if (CPU_ADDR === ad && CPU_PROG_FETCH === 1'b1 && BREAKPOINT_REQUEST !== 1'b1) t = 0;
    end
    if (BREAKPOINT_REQUEST !== 1'b1) begin
      chk("request timeout", 16'h0001, 16'h0000);
      finish_test();
    end else if (lat > 0) begin
      chk("latency", lat[15:0], t[15:0]);
    end
  endtask
  task automatic post(input logic [7:0] ec, input logic [7:0] es);
    repeat (2) @(posedge CLOCK);
    #1 chk("halt", 16'h0001, {TIMER_HALT, CAPTURE_BLOCK} == 2'b11);
    chk("watchdog", thv, WATCHDOG_DISABLE);
    chk("clear allow", exp_clear(1'b1, fce, req), STATUS_CLEAR_ALLOW);
    chk("vector", mon ? `ABU_VECTOR_MONITOR : `ABU_VECTOR_USER, BREAK_VECTOR);
    chk("irq", |(es[1:0] & msk), IRQ);
    rd(`ABU_OFS_CTRL_STATUS, v);
    chk("ctrl", ec, v);
    rd(`ABU_OFS_IRQ_STATUS, v);
    chk("irq status", es, v);
    wr(`ABU_OFS_IRQ_STATUS, 8'hff);
    wr(`ABU_OFS_CTRL_STATUS, 8'h00);
    rd(`ABU_OFS_CTRL_STATUS, v);
    chk("ctrl cleared", 16'h0000, v);
    chk("irq off", 16'h0000, IRQ);
    chk("halt released", 16'h0000, {TIMER_HALT, CAPTURE_BLOCK});
    chk("watchdog released", 16'h0000, WATCHDOG_DISABLE);
    chk("clear outside break", exp_clear(1'b0, fce, req), STATUS_CLEAR_ALLOW);
  endtask
  task automatic quiet(input int n);
    int h;
    h = 0;
    repeat (n) begin
      @(posedge CLOCK);
      #1 h += BREAKPOINT_REQUEST;
    end
    chk("no request", 16'h0000, h[15:0]);
  endtask
  initial begin
    {CLOCK, RST_B, REG_WR, REG_RD, CPU_WAIT_MODE, CPU_STOP_MODE} = 6'h00;
    {MONITOR_MODE, TEST_HIGH_VOLTAGE, REG_ADDR, REG_WDATA} = 14'h0000;
    STATUS_CLEAR_REQ = 1'b1;
    {fail_count, checked, fce, thv, mon, msk, req} = 0;
    seed = 16'h005c;
    repeat (20) @(posedge CLOCK);
    RST_B <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("reset", 16'h0000, v);
    end
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      a = {8'h01, CPU_ADDR[7:0] + 8'h40 + seed[4:0]};
      {req, fce, thv, mon, msk} = seed[13:8];
      @(posedge CLOCK);
      TEST_HIGH_VOLTAGE <= thv;
      MONITOR_MODE <= mon;
      STATUS_CLEAR_REQ <= req;
      wr(`ABU_OFS_ADDR_HIGH, a[15:8]);
      wr(`ABU_OFS_ADDR_LOW, a[7:0]);
      rd(`ABU_OFS_ADDR_HIGH, v);
      chk("addr high", a[15:8], v);
      rd(`ABU_OFS_ADDR_LOW, v);
      chk("addr low", a[7:0], v);
      wr(`ABU_OFS_FLAG_CONTROL, {fce, 7'h00});
      wr(`ABU_OFS_IRQ_MASK, {6'h00, msk});
      wr(`ABU_OFS_CTRL_STATUS, 8'h80);
      wait_req(a, a[0] ? 2 : 1);
      post(8'hc0, 8'h01);
    end
    wr(`ABU_OFS_ADDR_LOW, CPU_ADDR[7:0] + 8'h08);
    quiet(300);
    wr(`ABU_OFS_CTRL_STATUS, 8'h40);
    wait_req(16'hffff, 0);
    post(8'h40, 8'h02);
    for (int m = 0; m < 2; m++) begin
      @(posedge CLOCK);
      CPU_WAIT_MODE <= m == 0;
      CPU_STOP_MODE <= m == 1;
      repeat (2) @(posedge CLOCK);
      wr(`ABU_OFS_ADDR_LOW, CPU_ADDR[7:0]);
      wr(`ABU_OFS_CTRL_STATUS, 8'h80);
      quiet(16);
      rd(`ABU_OFS_CTRL_STATUS, v);
      chk("enable kept", 16'h0080, v);
    end
    @(posedge CLOCK);
    CPU_STOP_MODE <= 1'b0;
    CPU_WAIT_MODE <= 1'b1;
    wr(`ABU_OFS_CTRL_STATUS, 8'h40);
    repeat (3) @(posedge CLOCK);
    CPU_WAIT_MODE <= 1'b0;
    wait_req(16'hffff, 0);
    post(8'h40, 8'h02);
    rd(`ABU_OFS_WAIT_STATUS, v);
    chk("wait exit", 16'h0002, v);
    finish_test();
  end
endmodule // abu_breakpoint_tb

// [abu_cpu_model.sv]
`timescale 1ns/1ns
module abu_cpu_model (
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic        HOLD_BUS,
  input  wire logic        BREAKPOINT_REQUEST,
  output logic      [15:0] CPU_ADDR,
  output logic             CPU_PROG_FETCH,
  output logic             CPU_OPCODE_FETCH,
  output logic             CPU_INSTR_START,
  output logic             BREAK_STATE
);
  logic [7:0] pc_reg;
  logic [3:0] brk_reg;
  // frozen address in low power, fetch kept up so a careless compare would fire
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pc_reg <= 8'h00;
    end else if (!HOLD_BUS && !BREAK_STATE) begin
      pc_reg <= pc_reg + 8'h01;
    end
  end
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      brk_reg <= 4'h0;
    end else if (brk_reg != 4'h0) begin
      brk_reg <= brk_reg - 4'h1;
    end else if (BREAKPOINT_REQUEST && !HOLD_BUS) begin
      brk_reg <= 4'h8;
    end
  end
  assign BREAK_STATE = brk_reg != 4'h0;
  // address is not qualified in break, so show garbage there
  assign CPU_ADDR = BREAK_STATE ? ~{8'h01, pc_reg} : {8'h01, pc_reg};
  assign CPU_PROG_FETCH = !BREAK_STATE;
  assign CPU_OPCODE_FETCH = !pc_reg[0];
  assign CPU_INSTR_START = !pc_reg[0] && !BREAK_STATE && !HOLD_BUS;
endmodule // abu_cpu_model

// [abu_defines.svh]
`ifndef ABU_DEFINES_SVH
`define ABU_DEFINES_SVH

// register offsets on the plain register port
`define ABU_OFS_CTRL_STATUS   4'h0
`define ABU_OFS_ADDR_HIGH     4'h1
`define ABU_OFS_ADDR_LOW      4'h2
`define ABU_OFS_WAIT_STATUS   4'h3
`define ABU_OFS_FLAG_CONTROL  4'h4
`define ABU_OFS_IRQ_STATUS    4'h5
`define ABU_OFS_IRQ_MASK      4'h6

// field positions
`define ABU_BIT_MATCH_ENABLE  7
`define ABU_BIT_ACTIVE        6
`define ABU_BIT_WAIT_EXIT     1
`define ABU_BIT_CLEAR_ENABLE  7
`define ABU_BIT_IRQ_MATCH     0
`define ABU_BIT_IRQ_FORCED    1

// reset values
`define ABU_RST_CTRL          8'h00
`define ABU_RST_ADDR          8'h00
`define ABU_RST_FLAG_CONTROL  8'h00
`define ABU_RST_IRQ           8'h00

// software interrupt vectors
`define ABU_VECTOR_USER       16'hfffc
`define ABU_VECTOR_MONITOR    16'hfefc

`endif

// [abu_pkg.sv]
package abu_pkg;
  typedef enum logic [1:0] {
    ABU_IDLE_TYPE_IDLE      = 2'b00,
    ABU_IDLE_TYPE_OPERAND   = 2'b01,
    ABU_IDLE_TYPE_REQUEST   = 2'b10
  } abu_state_type;
endpackage
